// ==== dv/abx_host_model.sv ====
// Host audio processor model on the serial audio port of the pin block.
// Assumes the bench resolves pin levels from the device's output enables.
`timescale 1ns/100ps
module abx_host_model (
  input wire logic run_in,
  input wire logic sync_on_in,
  input wire logic hold_in,
  input wire logic level_in,
  output logic bclk_out,
  output logic fsync_out,
  output logic data_out
);
  logic [2:0] bit_cnt_ff;
  logic pat_ff;

  // Bit clock of 160 ns runs while the host is enabled, else stands low.
  initial begin
    bclk_out = 1'b0;
    #7;
    forever begin
      #80;
      bclk_out = run_in ? ~bclk_out : 1'b0;
    end
  end

  // Frame sync marks bit 0 of every 8-bit frame; data changes every bit.
  initial begin
    bit_cnt_ff = 3'h0;
    pat_ff = 1'b0;
    fsync_out = 1'b0;
    forever begin
      @(negedge bclk_out);
      bit_cnt_ff = bit_cnt_ff + 3'h1;
      pat_ff = ~pat_ff;
      fsync_out = sync_on_in && (bit_cnt_ff == 3'h0);
    end
  end

  // A held level lets the bench set what the receive pins carry.
  assign data_out = hold_in ? level_in : pat_ff;
endmodule

// ==== dv/abx_pins_bench.sv ====
// Self-checking bench for the pin function block with a host model.
// Assumes the design's constants header and package are compiled first.
`timescale 1ns/100ps
`include "abx_pins_cfg.svh"
module abx_pins_bench;
  logic core_clk, nrst, reg_wr, reg_rd, brownout, bclk_src, fsync_src;
  logic mic_clk, tx_a_d, tx_b_d, strap_a, strap_b_lvl, gpio_a_lvl;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, rdata;
  logic sb_o, sb_oe, bc_o, bc_oe, fs_o, fs_oe, ta_o, ta_oe, tb_o, tb_oe;
  logic ra_o, ra_oe, mc_o, mc_oe, bmain, fstart, rxa_d, rxb_d, mica;
  logic bus_rst, run, sync_on, hold, lvl, h_bclk, h_fs, h_dat;
  logic [1:0] i2c;
  logic [3:0] gedge;
  int n_fail = 0;
  int checks_done = 0;

  // Pin levels follow whichever party drives each wire.
  abx_pins #(.SYNC_LOSS_CYC(200)) u_dut (
    .core_clk_in(core_clk), .nrst_in(nrst), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(rdata), .brownout_in(brownout), .bclk_src_in(bclk_src),
    .fsync_src_in(fsync_src), .mic_clk_in(mic_clk),
    .tx_a_data_in(tx_a_d), .tx_b_data_in(tx_b_d),
    .addr_strap_a_pin_in(strap_a),
    .addr_strap_b_pin_in(sb_oe ? sb_o : strap_b_lvl),
    .addr_strap_b_pin_out(sb_o), .addr_strap_b_pin_oe_out(sb_oe),
    .bclk_pin_in(bc_oe ? bc_o : h_bclk), .bclk_pin_out(bc_o),
    .bclk_pin_oe_out(bc_oe), .fsync_pin_in(fs_oe ? fs_o : h_fs),
    .fsync_pin_out(fs_o), .fsync_pin_oe_out(fs_oe),
    .tdm_tx_a_pin_in(ta_oe ? ta_o : gpio_a_lvl), .tdm_tx_a_pin_out(ta_o),
    .tdm_tx_a_pin_oe_out(ta_oe), .tdm_tx_b_pin_in(tb_oe ? tb_o : h_dat),
    .tdm_tx_b_pin_out(tb_o), .tdm_tx_b_pin_oe_out(tb_oe),
    .tdm_rx_a_pin_in(ra_oe ? ra_o : h_dat), .tdm_rx_a_pin_out(ra_o),
    .tdm_rx_a_pin_oe_out(ra_oe), .mic_clock_out(mc_o),
    .mic_clock_oe_out(mc_oe), .i2c_addr_out(i2c), .bclk_main_out(bmain),
    .frame_start_out(fstart), .rx_a_data_out(rxa_d),
    .tdm_rx_b_function_out(rxb_d), .mic_input_a_out(mica),
    .bus_reset_out(bus_rst), .gpio_edge_out(gedge));

  abx_host_model u_host (.run_in(run), .sync_on_in(sync_on),
    .hold_in(hold), .level_in(lvl), .bclk_out(h_bclk), .fsync_out(h_fs),
    .data_out(h_dat));

  // Core clock of 50 MHz.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Compares one value and counts the result.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Waits whole cycles and steps past the edge so outputs have settled.
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // One-cycle register write.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle register read; data is taken in the following cycle.
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp,
                        input string msg);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(rdata, exp, msg);
  endtask

  // Resets with given strap levels and waits until the straps are latched.
  task automatic rst(input logic [1:0] s);
    nrst <= 1'b0;
    strap_a <= s[0];
    strap_b_lvl <= s[1];
    cyc(2);
    nrst <= 1'b1;
    cyc(6);
  endtask

  // Every strap setting gives its own address; strap B and data pins float after reset.
  task automatic t_strap();
    for (int i = 0; i < 4; i++) begin
      rst(i[1:0]);
      chk(8'(i2c), i[7:0], "strap address");
      chk(8'({sb_oe, ta_oe, tb_oe, ra_oe}), 8'h00, "pins after reset");
      rd_chk(`ABX_REG_STATUS, i[7:0], "status address");
    end
    rd_chk(`ABX_REG_FUNC, 8'h00, "function reset value");
  endtask

  // Subordinate drives clock and sync; main makes them inputs.
  task automatic t_sub();
    bclk_src <= 1'b1;
    fsync_src <= 1'b1;
    cyc(3);
    chk(8'({bc_oe, fs_oe, bc_o, fs_o}), 8'h0f, "sub clock pins");
    wr(`ABX_REG_FUNC, 8'hc0);
    bclk_src <= 1'b0;
    mic_clk <= 1'b1;
    cyc(3);
    chk(8'({bc_o, mc_oe, mc_o}), 8'h07, "mic clock pins");
    wr(`ABX_REG_FUNC, 8'h00);
    wr(`ABX_REG_CTRL, 8'h01);
    cyc(3);
    chk(8'({bc_oe, fs_oe, bmain}), 8'h01, "main clock pins");
    wr(`ABX_REG_CTRL, 8'h00);
  endtask

  // Strap B pin as interrupting GPIO, then as divided clock output.
  task automatic t_strapb();
    logic ok;
    logic prev;
    int n;
    wr(`ABX_REG_GPIO_OE, 8'h01);
    wr(`ABX_REG_GPIO_OUT, 8'h01);
    wr(`ABX_REG_FUNC, 8'h01);
    cyc(3);
    chk(8'({sb_oe, sb_o}), 8'h03, "strap B gpio drive");
    wr(`ABX_REG_GPIO_OE, 8'h00);
    strap_b_lvl <= 1'b0;
    ok = 1'b0;
    repeat (8) begin
      cyc(1);
      if (gedge[0] === 1'b1) ok = 1'b1;
    end
    chk(8'(ok), 8'h01, "strap B gpio edge");
    wr(`ABX_REG_CLKDIV, 8'h01);
    wr(`ABX_REG_FUNC, 8'h02);
    cyc(3);
    n = 0;
    prev = sb_o;
    repeat (8) begin
      cyc(1);
      if (sb_o !== prev) n++;
      prev = sb_o;
    end
    chk({sb_oe, n[6:0]}, 8'h84, "clock out toggles");
    wr(`ABX_REG_FUNC, 8'h00);
    cyc(3);
    chk(8'(sb_oe), 8'h00, "strap B floats");
  endtask

  // Data pin functions and their GPIO fallbacks.
  task automatic t_data();
    wr(`ABX_REG_FUNC, 8'h04);
    tx_a_d <= 1'b1;
    cyc(3);
    chk(8'({ta_oe, ta_o}), 8'h03, "tx A data");
    wr(`ABX_REG_FUNC, 8'h00);
    tx_a_d <= 1'b0;
    wr(`ABX_REG_GPIO_OE, 8'h0e);
    wr(`ABX_REG_GPIO_OUT, 8'h0e);
    cyc(3);
    chk(8'({ta_oe, ta_o, tb_oe, tb_o}), 8'h0f, "gpio 3 and 4");
    chk(8'({ra_oe, ra_o}), 8'h03, "gpio five drive");
    wr(`ABX_REG_GPIO_OE, 8'h00);
    wr(`ABX_REG_FUNC, 8'h18);
    tx_b_d <= 1'b0;
    cyc(3);
    chk(8'({tb_oe, tb_o}), 8'h02, "tx B wins");
    wr(`ABX_REG_FUNC, 8'h10);
    hold <= 1'b1;
    lvl <= 1'b1;
    cyc(4);
    chk(8'({tb_oe, rxb_d}), 8'h01, "tx B pin receives");
    wr(`ABX_REG_FUNC, 8'h20);
    cyc(4);
    chk(8'({ra_oe, rxa_d, mica}), 8'h02, "rx A tdm");
    wr(`ABX_REG_FUNC, 8'h40);
    cyc(4);
    chk(8'({rxa_d, mica, mc_oe}), 8'h03, "rx A mic");
    wr(`ABX_REG_FUNC, 8'h00);
    gpio_a_lvl <= 1'b0;
    cyc(4);
    rd_chk(`ABX_REG_GPIO_IN, 8'h0c, "gpio five input");
    wr(3'h7, 8'hff);
    rd_chk(3'h7, 8'h00, "unmapped index");
  endtask

  // Frames in main mode, then frame sync stops and the bus resets.
  task automatic t_sync();
    int n;
    int bad;
    logic ok;
    run <= 1'b1;
    sync_on <= 1'b1;
    hold <= 1'b0;
    wr(`ABX_REG_CTRL, 8'h01);
    wr(`ABX_REG_FUNC, 8'h04);
    n = 0;
    bad = 0;
    repeat (640) begin
      cyc(1);
      if (fstart === 1'b1) n++;
      if (bus_rst !== 1'b0) bad++;
    end
    chk(8'(n >= 9 && n <= 11), 8'h01, "frame starts");
    chk(8'(bad != 0), 8'h00, "no reset while framed");
    sync_on <= 1'b0;
    ok = 1'b0;
    repeat (300) if (!ok) begin
      cyc(1);
      if (bus_rst === 1'b1) ok = 1'b1;
    end
    chk(8'(ok), 8'h01, "bus reset on sync loss");
    cyc(2);
    chk(8'(ta_oe), 8'h00, "tx A floats after loss");
    rd_chk(`ABX_REG_STATUS, 8'h0f, "lost flag");
    rd_chk(`ABX_REG_FUNC, 8'h00, "function cleared");
    sync_on <= 1'b1;
    wr(`ABX_REG_CTRL, 8'h00);
    wr(`ABX_REG_STATUS, 8'h04);
    rd_chk(`ABX_REG_STATUS, 8'h03, "lost cleared");
    run <= 1'b0;
  endtask

  // Low supply floats the data pins and clears their functions.
  task automatic t_brown();
    wr(`ABX_REG_FUNC, 8'h04);
    cyc(3);
    chk(8'(ta_oe), 8'h01, "tx A drives before brownout");
    brownout <= 1'b1;
    cyc(5);
    chk(8'(ta_oe), 8'h00, "tx A floats on brownout");
    brownout <= 1'b0;
    rd_chk(`ABX_REG_FUNC, 8'h00, "brownout clears");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence.
  initial begin
    {nrst, reg_wr, reg_rd, brownout, bclk_src, fsync_src} = 6'h00;
    {mic_clk, tx_a_d, tx_b_d, strap_a, strap_b_lvl, gpio_a_lvl} = 6'h01;
    {run, sync_on, hold, lvl} = 4'h0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    t_strap();
    t_sub();
    t_strapb();
    t_data();
    t_sync();
    t_brown();
    stop_test();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    #500000;
    n_fail++;
    stop_test();
  end
endmodule

// ==== rtl/abx_pins.sv ====
// Pin function selection for the serial audio and strap pins.
// Assumes pin inputs are asynchronous and core-side data is on core_clk_in.
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "abx_pins_cfg.svh"
module abx_pins
  import abx_pins_pkg::*;
#(
  parameter bit HAS_SERIAL = 1'b1,
  parameter int SYNC_LOSS_CYC = `ABX_SYNC_LOSS_CYC
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic brownout_in,
  input wire logic bclk_src_in,
  input wire logic fsync_src_in,
  input wire logic mic_clk_in,
  input wire logic tx_a_data_in,
  input wire logic tx_b_data_in,
  input wire logic addr_strap_a_pin_in,
  input wire logic addr_strap_b_pin_in,
  output logic addr_strap_b_pin_out,
  output logic addr_strap_b_pin_oe_out,
  input wire logic bclk_pin_in,
  output logic bclk_pin_out,
  output logic bclk_pin_oe_out,
  input wire logic fsync_pin_in,
  output logic fsync_pin_out,
  output logic fsync_pin_oe_out,
  input wire logic tdm_tx_a_pin_in,
  output logic tdm_tx_a_pin_out,
  output logic tdm_tx_a_pin_oe_out,
  input wire logic tdm_tx_b_pin_in,
  output logic tdm_tx_b_pin_out,
  output logic tdm_tx_b_pin_oe_out,
  input wire logic tdm_rx_a_pin_in,
  output logic tdm_rx_a_pin_out,
  output logic tdm_rx_a_pin_oe_out,
  output logic mic_clock_out,
  output logic mic_clock_oe_out,
  output logic [1:0] i2c_addr_out,
  output logic bclk_main_out,
  output logic frame_start_out,
  output logic rx_a_data_out,
  output logic tdm_rx_b_function_out,
  output logic mic_input_a_out,
  output logic bus_reset_out,
  output logic [3:0] gpio_edge_out
);

  logic [7:0] pin_s;
  logic sa_s, sb_s, bclk_s, fs_s, txa_s, txb_s, rxa_s, bo_s;
  logic main_ff, lost_ff, fs_d_ff, clkout_ff, bus_reset_ff;
  logic [7:0] func_ff, div_ff, div_cnt_ff;
  logic [3:0] gpio_oe_ff, gpio_out_ff, gpio_d_ff, gpio_in;
  logic [1:0] fill_ff;
  logic [15:0] loss_cnt_ff;
  abx_strap_st_t st_ff;
  abx_sb_func_t sb_func;
  logic run, fs_edge, fs_rise, loss_hit, cfg_clr;
  logic txa_on, txb_on, rxb_on, rxa_tdm, mic_on;

  // All pin inputs pass the two-stage synchroniser.
  abx_sync #(.W(8)) u_sync (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .d_in({addr_strap_a_pin_in, addr_strap_b_pin_in, bclk_pin_in,
           fsync_pin_in, tdm_tx_a_pin_in, tdm_tx_b_pin_in,
           tdm_rx_a_pin_in, brownout_in}),
    .q_out(pin_s)
  );
  assign {sa_s, sb_s, bclk_s, fs_s, txa_s, txb_s, rxa_s, bo_s} = pin_s;

  // Decoded configuration; serial port functions vanish on reduced parts.
  assign sb_func = abx_sb_func_t'(func_ff[1:0]);
  assign txa_on = HAS_SERIAL & func_ff[`ABX_FUNC_TXA_EN]; // RL15
  assign txb_on = HAS_SERIAL & func_ff[`ABX_FUNC_TXB_EN];
  assign rxb_on = HAS_SERIAL & func_ff[`ABX_FUNC_RXB_ALT] & ~txb_on;
  assign rxa_tdm = HAS_SERIAL & func_ff[`ABX_FUNC_RXA_TDM]; // RL15
  assign mic_on = func_ff[`ABX_FUNC_MICA_EN];
  assign run = (st_ff == ABX_ST_RUN);
  assign gpio_in = {rxa_s, txb_s, txa_s, sb_s};

  // Strap capture waits for the synchroniser to fill after reset.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_ff <= ABX_ST_FILL;
      fill_ff <= 2'h0;
      i2c_addr_out <= 2'h0;
    end else begin
      case (st_ff)
        ABX_ST_FILL: begin
          fill_ff <= fill_ff + 2'h1;
          if (fill_ff == `ABX_STRAP_FILL) begin
            st_ff <= ABX_ST_LATCH;
          end
        end
        ABX_ST_LATCH: begin
          i2c_addr_out <= {sb_s, sa_s}; // RL1
          st_ff <= ABX_ST_RUN;
        end
        ABX_ST_RUN: st_ff <= ABX_ST_RUN;
        default: st_ff <= ABX_ST_FILL;
      endcase
    end
  end

  // Frame sync edges; silence on a main node counts toward a bus reset.
  assign fs_edge = fs_s ^ fs_d_ff;
  assign fs_rise = fs_s & ~fs_d_ff;
  assign loss_hit = main_ff && run && !fs_edge &&
                    (loss_cnt_ff == 16'(SYNC_LOSS_CYC - 1));
  assign cfg_clr = loss_hit | bo_s;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fs_d_ff <= 1'b0;
      loss_cnt_ff <= 16'h0000;
      bus_reset_ff <= 1'b0;
      frame_start_out <= 1'b0;
    end else begin
      fs_d_ff <= fs_s;
      bus_reset_ff <= loss_hit; // RL9
      frame_start_out <= main_ff & run & fs_rise; // RL7
      if (!main_ff || !run || fs_edge || loss_hit) begin
        loss_cnt_ff <= 16'h0000;
      end else begin
        loss_cnt_ff <= loss_cnt_ff + 16'h0001; // RL9
      end
    end
  end
  assign bus_reset_out = bus_reset_ff;

  // Configuration registers; sync loss or brownout returns the strap B and data pins to float.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      main_ff <= 1'b0;
      func_ff <= `ABX_RST_BYTE;
      gpio_oe_ff <= `ABX_RST_NIB;
      gpio_out_ff <= `ABX_RST_NIB;
      div_ff <= `ABX_RST_BYTE;
    end else if (cfg_clr) begin
      func_ff <= `ABX_RST_BYTE; // RL11
      gpio_oe_ff <= `ABX_RST_NIB;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `ABX_REG_CTRL: main_ff <= reg_wdata_in[0];
        `ABX_REG_FUNC: func_ff <= reg_wdata_in;
        `ABX_REG_GPIO_OE: gpio_oe_ff <= reg_wdata_in[3:0];
        `ABX_REG_GPIO_OUT: gpio_out_ff <= reg_wdata_in[3:0];
        `ABX_REG_CLKDIV: div_ff <= reg_wdata_in;
        default: main_ff <= main_ff;
      endcase
    end
  end
  assign bclk_main_out = main_ff;

  // Sticky sync loss flag; a new loss wins over a write-one clear.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lost_ff <= 1'b0;
    end else if (loss_hit) begin
      lost_ff <= 1'b1;
    end else if (reg_wr_in && reg_addr_in == `ABX_REG_STATUS &&
                 reg_wdata_in[`ABX_STAT_LOST]) begin
      lost_ff <= 1'b0;
    end
  end

  // Read data is registered and stands for the cycle after the strobe.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `ABX_REG_CTRL: reg_rdata_out <= {7'h00, main_ff};
        `ABX_REG_FUNC: reg_rdata_out <= func_ff;
        `ABX_REG_GPIO_OE: reg_rdata_out <= {4'h0, gpio_oe_ff};
        `ABX_REG_GPIO_OUT: reg_rdata_out <= {4'h0, gpio_out_ff};
        `ABX_REG_GPIO_IN: reg_rdata_out <= {4'h0, gpio_in};
        `ABX_REG_STATUS: reg_rdata_out <= {4'h0, main_ff, lost_ff,
                                          i2c_addr_out};
        `ABX_REG_CLKDIV: reg_rdata_out <= div_ff;
        default: reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // Auxiliary clock: toggles every div_ff+1 core cycles.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_cnt_ff <= 8'h00;
      clkout_ff <= 1'b0;
    end else if (div_cnt_ff >= div_ff) begin
      div_cnt_ff <= 8'h00;
      clkout_ff <= ~clkout_ff; // RL3
    end else begin
      div_cnt_ff <= div_cnt_ff + 8'h01;
    end
  end

  // Interrupt-capable GPIO inputs report an edge while in input mode.
  logic [3:0] gpio_mode;
  assign gpio_mode = {~rxa_tdm & ~mic_on, ~txb_on & ~rxb_on, ~txa_on,
                      sb_func == ABX_SB_GPIO};
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gpio_d_ff <= 4'h0;
    end else begin
      gpio_d_ff <= gpio_in;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_edge
      always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          gpio_edge_out[gi] <= 1'b0;
        end else begin
          gpio_edge_out[gi] <= run & gpio_mode[gi] & ~gpio_oe_ff[gi] &
                               (gpio_in[gi] ^ gpio_d_ff[gi]); // RL2
        end
      end
    end
  endgenerate

  // Strap B pin: float, GPIO or clock output.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      addr_strap_b_pin_oe_out <= 1'b0;
      addr_strap_b_pin_out <= 1'b0;
    end else begin
      case (sb_func)
        ABX_SB_GPIO: begin
          addr_strap_b_pin_oe_out <= run & gpio_oe_ff[0]; // RL2
          addr_strap_b_pin_out <= gpio_out_ff[0];
        end
        ABX_SB_CLKOUT: begin
          addr_strap_b_pin_oe_out <= run; // RL3
          addr_strap_b_pin_out <= clkout_ff;
        end
        default: begin
          addr_strap_b_pin_oe_out <= 1'b0; // RL2
          addr_strap_b_pin_out <= 1'b0;
        end
      endcase
    end
  end

  // Clock and frame pins: inputs on a main node, outputs on subordinates.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bclk_pin_oe_out <= 1'b0;
      bclk_pin_out <= 1'b0;
      fsync_pin_oe_out <= 1'b0;
      fsync_pin_out <= 1'b0;
      mic_clock_oe_out <= 1'b0;
      mic_clock_out <= 1'b0;
    end else begin
      bclk_pin_oe_out <= run & ~main_ff; // RL4
      bclk_pin_out <= (mic_on & func_ff[`ABX_FUNC_BCLK_MIC]) ?
                      mic_clk_in : bclk_src_in; // RL5
      fsync_pin_oe_out <= run & ~main_ff; // RL6
      fsync_pin_out <= fsync_src_in; // RL7
      mic_clock_oe_out <= run & mic_on;
      mic_clock_out <= mic_clk_in;
    end
  end

  // Transmit A and B pins.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tdm_tx_a_pin_oe_out <= 1'b0;
      tdm_tx_a_pin_out <= 1'b0;
      tdm_tx_b_pin_oe_out <= 1'b0;
      tdm_tx_b_pin_out <= 1'b0;
    end else begin
      if (txa_on) begin
        tdm_tx_a_pin_oe_out <= run; // RL10
        tdm_tx_a_pin_out <= tx_a_data_in;
      end else begin
        tdm_tx_a_pin_oe_out <= run & gpio_oe_ff[1]; // RL10
        tdm_tx_a_pin_out <= gpio_out_ff[1];
      end
      if (txb_on) begin
        tdm_tx_b_pin_oe_out <= run; // RL12
        tdm_tx_b_pin_out <= tx_b_data_in;
      end else if (rxb_on) begin
        tdm_tx_b_pin_oe_out <= 1'b0; // RL12
        tdm_tx_b_pin_out <= 1'b0;
      end else begin
        tdm_tx_b_pin_oe_out <= run & gpio_oe_ff[2]; // RL13
        tdm_tx_b_pin_out <= gpio_out_ff[2];
      end
    end
  end

  // Receive A pin and received data toward the core.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tdm_rx_a_pin_oe_out <= 1'b0;
      tdm_rx_a_pin_out <= 1'b0;
      rx_a_data_out <= 1'b0;
      mic_input_a_out <= 1'b0;
      tdm_rx_b_function_out <= 1'b0;
    end else begin
      tdm_rx_a_pin_oe_out <= run & ~rxa_tdm & ~mic_on & gpio_oe_ff[3]; // RL14
      tdm_rx_a_pin_out <= gpio_out_ff[3];
      rx_a_data_out <= rxa_tdm & rxa_s; // RL14
      mic_input_a_out <= mic_on & rxa_s;
      tdm_rx_b_function_out <= rxb_on & txb_s; // RL12
    end
  end

  // Checks.
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  chk_strap_stable: assert property ( // RL1
    $past(run) |-> $stable(i2c_addr_out))
    else $error("strap address changed after capture");
  chk_strap_b_float: assert property ( // RL2
    (sb_func == ABX_SB_HIZ) |=> !addr_strap_b_pin_oe_out)
    else $error("strap B pin driven while floating");
  chk_clkout_follow: assert property ( // RL3
    (run && sb_func == ABX_SB_CLKOUT) |=>
    addr_strap_b_pin_oe_out && addr_strap_b_pin_out == $past(clkout_ff))
    else $error("clock output not on strap B pin");
  chk_bclk_dir: assert property ( // RL4
    run |=> bclk_pin_oe_out == !$past(main_ff))
    else $error("bit clock direction wrong");
  chk_bclk_mic: assert property ( // RL5
    (mic_on && func_ff[`ABX_FUNC_BCLK_MIC]) |=>
    bclk_pin_out == $past(mic_clk_in))
    else $error("bit clock pin not carrying mic clock");
  chk_fsync_dir: assert property ( // RL6
    run |=> fsync_pin_oe_out == !$past(main_ff))
    else $error("frame sync direction wrong");
  chk_frame_mark: assert property ( // RL7
    (main_ff && run && fs_rise) |=> frame_start_out)
    else $error("frame start not marked");
  chk_sync_loss: assert property ( // RL9
    (main_ff && run && fs_edge) |=> !bus_reset_out [*2])
    else $error("bus reset despite frame sync activity");
  chk_tx_a_drive: assert property ( // RL10
    (run && txa_on && !cfg_clr) |=>
    tdm_tx_a_pin_oe_out && tdm_tx_a_pin_out == $past(tx_a_data_in))
    else $error("transmit A not driving data");
  chk_cfg_clear: assert property ( // RL11
    bus_reset_out |-> func_ff == 8'h00 ##1 !tdm_tx_a_pin_oe_out &&
    !tdm_tx_b_pin_oe_out && !tdm_rx_a_pin_oe_out)
    else $error("pins not floating after sync loss");
  chk_tx_b_alt: assert property ( // RL12
    rxb_on |=> !tdm_tx_b_pin_oe_out)
    else $error("transmit B driven in receive mode");
  chk_gpio_four: assert property ( // RL13
    (run && !txb_on && !rxb_on && !cfg_clr) |=>
    tdm_tx_b_pin_oe_out == $past(gpio_oe_ff[2]))
    else $error("transmit B not acting as GPIO");
  chk_rx_a_input: assert property ( // RL14
    (rxa_tdm || mic_on) |=> !tdm_rx_a_pin_oe_out)
    else $error("receive A driven while receiving");
  chk_variant: assert property ( // RL15
    !HAS_SERIAL |-> !txa_on && !txb_on && !rxa_tdm)
    else $error("serial function on reduced variant");

  cov_sync_loss: cover property (bus_reset_out);
  cov_clkout: cover property (addr_strap_b_pin_oe_out && run &&
                              sb_func == ABX_SB_CLKOUT);
  cov_rx_b_alt: cover property (rxb_on ##1 tdm_rx_b_function_out);

endmodule

// ==== rtl/abx_pins_cfg.svh ====
// Constants for the audio bus transceiver pin function block.
// Assumes a 50 MHz core clock and a 3-bit register index on a plain port.
// Behaviour
// RL1: Two strap pins sampled at reset pick one of four I2C target addresses.
// RL2: Strap B pin floats by default and may become an interrupting GPIO.
// RL3: Strap B pin can be programmed as a divided clock output.
// RL4: Bit clock pin is input on the main node, driven output on subordinates.
// RL5: Subordinate bit clock pin may carry the microphone clock instead.
// RL6: Frame sync pin is input on the main node, output on subordinates.
// RL7: Frame sync marks frame boundaries of the TDM data stream.
// RL8: Host feeding a main node supplies a continuously toggling frame sync.
// RL9: Frame sync that stops toggling resets the bus after a delay.
// RL10: Transmit A pin drives TDM data when enabled, else acts as GPIO three.
// RL11: Data pins float until configured and after sync loss or brownout.
// RL12: Transmit B pin drives TDM data or receives the second stream instead.
// RL13: Transmit B pin is GPIO four when both its functions are off.
// RL14: Receive A pin takes TDM or microphone data, else acts as GPIO five.
// RL15: Reduced variants: transmit pins are GPIO only, receive A has no TDM.
`ifndef ABX_PINS_CFG_SVH
`define ABX_PINS_CFG_SVH

// Register indices.
`define ABX_REG_CTRL 3'h0
`define ABX_REG_FUNC 3'h1
`define ABX_REG_GPIO_OE 3'h2
`define ABX_REG_GPIO_OUT 3'h3
`define ABX_REG_GPIO_IN 3'h4
`define ABX_REG_STATUS 3'h5
`define ABX_REG_CLKDIV 3'h6

// Function register fields.
`define ABX_FUNC_STRAPB_LO 0
`define ABX_FUNC_TXA_EN 2
`define ABX_FUNC_TXB_EN 3
`define ABX_FUNC_RXB_ALT 4
`define ABX_FUNC_RXA_TDM 5
`define ABX_FUNC_MICA_EN 6
`define ABX_FUNC_BCLK_MIC 7

// Status register fields.
`define ABX_STAT_LOST 2
`define ABX_STAT_MAIN 3

// Reset values.
`define ABX_RST_BYTE 8'h00
`define ABX_RST_NIB 4'h0

// Timing: frame sync silence before a bus reset.
`define ABX_CLK_NS 20
`define ABX_SYNC_LOSS_NS 20000
`define ABX_SYNC_LOSS_CYC (`ABX_SYNC_LOSS_NS / `ABX_CLK_NS)
`define ABX_STRAP_FILL 2'h2

`endif

// ==== rtl/abx_pins_pkg.sv ====
// Types for the audio bus transceiver pin function block.
// Assumes the constants header is included by the modules.
package abx_pins_pkg;

  // Function of the strap B pin after reset.
  typedef enum logic [1:0] {
    ABX_SB_HIZ,
    ABX_SB_GPIO,
    ABX_SB_CLKOUT,
    ABX_SB_RSVD
  } abx_sb_func_t;

  // Strap capture sequence.
  typedef enum logic [1:0] {
    ABX_ST_FILL,
    ABX_ST_LATCH,
    ABX_ST_RUN
  } abx_strap_st_t;

endpackage

// ==== rtl/abx_sync.sv ====
// Two flip-flop synchroniser, one per bit.
// Assumes inputs are asynchronous to core_clk_in.
`timescale 1ns/100ps
module abx_sync #(
  parameter int W = 8
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta_ff;

  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_ff <= '0;
      q_out <= '0;
    end else begin
      meta_ff <= d_in;
      q_out <= meta_ff;
    end
  end

endmodule
